/* File: hw/adc_fmt_map.vh */
// register offsets, field positions, reset values and timing figures of the
// output format configuration block; definitions only
`ifndef ADC_FMT_MAP_VH
`define ADC_FMT_MAP_VH

// serial port framing
`define SPI_INSTR_BITS 5'h10
`define SPI_RW_BIT 15
`define SPI_LEN_HI 14
`define SPI_LEN_LO 13
`define SPI_ADDR_HI 12
`define SPI_BYTE_LAST 3'h7

// register offsets
`define ADDR_OUT_FORMAT 13'h0014
`define ADDR_OUT_DRIVE 13'h0015
`define ADDR_OUT_PHASE 13'h0016
`define ADDR_OUT_DELAY 13'h0017
`define ADDR_PATT1_LOW 13'h0019
`define ADDR_PATT1_HIGH 13'h001A

// reset values
`define RST_OUT_FORMAT 8'h00
`define RST_OUT_DRIVE 8'h22
`define RST_OUT_PHASE 8'h00
`define RST_OUT_DELAY 8'h00
`define RST_PATT 8'h00

// implemented bits per register; open bits read as zero
`define MASK_OUT_FORMAT 8'hD7
`define MASK_OUT_DRIVE 8'hFF
`define MASK_OUT_PHASE 8'h87
`define MASK_OUT_DELAY 8'hA7

// output format fields
`define FMT_CODE_HI 1
`define FMT_CODE_LO 0
`define FMT_INVERT_BIT 2
`define FMT_DISABLE_BIT 4
`define FMT_SUPPLY_HI 7
`define FMT_SUPPLY_LO 6
`define CODE_OFFSET_BIN 2'h0
`define CODE_TWOS 2'h1
`define CODE_GRAY 2'h2

// output phase fields
`define PHASE_INVERT_BIT 7
`define PHASE_ADJ_HI 2
`define PHASE_ADJ_LO 0

// output delay fields
`define DLY_CLK_EN_BIT 7
`define DLY_DATA_EN_BIT 5
`define DLY_CODE_HI 2
`define DLY_CODE_LO 0

// fine delay timing: step in ps and clock period in ps
`define DLY_STEP_PS 560
`define CLK_PERIOD_PS 4000

`endif

/* File: hw/fine_delay_line.v */
// tapped delay line used for the fine output delay of clock and data
// assumes one clock; tap 0 means one register stage with no added delay
`timescale 1ns/100ps

module fine_delay_line #(
    parameter WIDTH = 12,
    parameter DEPTH = 2,
    parameter SEL_W = 2
) (
    // clock and reset
    input wire clock_in,
    input wire nrst_in,
    // data and tap select
    input wire [WIDTH-1:0] data_in,
    input wire [SEL_W-1:0] tap_in,
    output reg [WIDTH-1:0] data_out
);

    reg [WIDTH*DEPTH-1:0] pipe_reg;
    wire [WIDTH*(DEPTH+1)-1:0] taps;

    assign taps = {pipe_reg, data_in};

    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pipe_reg <= {(WIDTH*DEPTH){1'b0}};
            data_out <= {WIDTH{1'b0}};
        end else begin
            pipe_reg <= taps[WIDTH*DEPTH-1:0];
            data_out <= taps[tap_in*WIDTH +: WIDTH];
        end
    end

endmodule

/* File: hw/adc_output_format_config.v */
// output format configuration registers and output formatter of the converter
// assumes serial port pins and sample inputs are synchronous to clock_in, and that
// enc_tick_in marks one input (sample) clock cycle as a one-cycle enable
//
// Notes on behaviour
// - format field picks offset binary, twos, gray
// - supply select field drives output supply setting
// - phase bit 7 inverts the output clock
// - phase adjust delays output clock 0..7 cycles
// - phase picks divider phase; latching stays fixed
// - fine delay touches only output edges
// - fine delay 0.56 ns steps rounded up to whole clocks, separate enables
`timescale 1ns/100ps
`include "adc_fmt_map.vh"

module adc_output_format_config #(
    parameter SAMPLE_W = 12,
    parameter DLY_DEPTH = ((8 * `DLY_STEP_PS) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS
) (
    // clock and reset
    input wire clock_in,
    input wire nrst_in,
    // serial control port
    input wire sclk_in,
    input wire csb_n_in,
    input wire sdio_in,
    output reg sdio_out,
    output reg sdio_oe_out,
    // conversion side
    input wire enc_tick_in,
    input wire [2:0] clk_div_ratio_in,
    input wire user_pattern_sel_in,
    input wire [SAMPLE_W-1:0] sample_in,
    // output pins
    output wire [SAMPLE_W-1:0] data_out,
    output reg data_oe_out,
    output wire output_sample_clock_out,
    output reg [1:0] io_supply_sel_out,
    output reg [7:0] drive_strength_out,
    output reg [15:0] user_pattern_one_out
);

    // ----------------------------------------
    // serial port
    // ----------------------------------------
    reg [7:0] fmt_reg, drive_reg, phase_reg, delay_reg, patt_lo_reg, patt_hi_reg;
    reg sclk_d_reg;
    reg [4:0] instr_cnt_reg;
    reg [15:0] instr_reg;
    reg [12:0] addr_reg;
    reg [2:0] bit_cnt_reg;
    reg [7:0] wr_shift_reg;
    reg [7:0] rd_shift_reg;
    reg [2:0] bytes_left_reg;
    reg stream_reg;
    reg active_reg;
    reg [7:0] rd_data;
    wire sclk_rise = sclk_in & ~sclk_d_reg;
    wire sclk_fall = ~sclk_in & sclk_d_reg;
    wire in_instr = (instr_cnt_reg != `SPI_INSTR_BITS);
    wire instr_done = sclk_rise & (instr_cnt_reg == `SPI_INSTR_BITS - 5'h01);
    wire is_read = instr_reg[`SPI_RW_BIT];
    wire byte_done = sclk_rise & ~in_instr & active_reg & (bit_cnt_reg == `SPI_BYTE_LAST);
    wire wr_strobe = byte_done & ~is_read;
    wire [7:0] wr_byte = {wr_shift_reg[6:0], sdio_in};
    wire [15:0] next_instr = {instr_reg[14:0], sdio_in};

    always @* begin
        case (addr_reg)
            `ADDR_OUT_FORMAT: rd_data = fmt_reg;
            `ADDR_OUT_DRIVE: rd_data = drive_reg;
            `ADDR_OUT_PHASE: rd_data = phase_reg;
            `ADDR_OUT_DELAY: rd_data = delay_reg;
            `ADDR_PATT1_LOW: rd_data = patt_lo_reg;
            `ADDR_PATT1_HIGH: rd_data = patt_hi_reg;
            default: rd_data = 8'h00;
        endcase
    end

    // msb first; length field 11 streams until chip select rises
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_d_reg <= 1'b0;
            instr_cnt_reg <= 5'h00;
            instr_reg <= 16'h0000;
            addr_reg <= 13'h0000;
            bit_cnt_reg <= 3'h0;
            wr_shift_reg <= 8'h00;
            rd_shift_reg <= 8'h00;
            bytes_left_reg <= 3'h0;
            stream_reg <= 1'b0;
            active_reg <= 1'b0;
            sdio_out <= 1'b0;
            sdio_oe_out <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_in;
            if (csb_n_in) begin
                instr_cnt_reg <= 5'h00;
                bit_cnt_reg <= 3'h0;
                active_reg <= 1'b0;
                sdio_oe_out <= 1'b0;
            end else begin
                if (sclk_rise && in_instr) begin
                    instr_reg <= next_instr;
                    instr_cnt_reg <= instr_cnt_reg + 5'h01;
                end
                if (instr_done) begin
                    addr_reg <= next_instr[`SPI_ADDR_HI:0];
                    bytes_left_reg <= {1'b0, next_instr[`SPI_LEN_HI:`SPI_LEN_LO]};
                    stream_reg <= &next_instr[`SPI_LEN_HI:`SPI_LEN_LO];
                    active_reg <= 1'b1;
                    bit_cnt_reg <= 3'h0;
                end
                if (sclk_rise && !in_instr && active_reg) begin
                    wr_shift_reg <= wr_byte;
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                end
                if (byte_done) begin
                    addr_reg <= addr_reg + 13'h0001;
                    if (!stream_reg) begin
                        if (bytes_left_reg == 3'h0) begin
                            active_reg <= 1'b0;
                        end
                        bytes_left_reg <= bytes_left_reg - 3'h1;
                    end
                end
                // read data changes on the falling edge so the host samples it stable
                if (sclk_fall && !in_instr && active_reg && is_read) begin
                    sdio_oe_out <= 1'b1;
                    if (bit_cnt_reg == 3'h0) begin
                        sdio_out <= rd_data[7];
                        rd_shift_reg <= {rd_data[6:0], 1'b0};
                    end else begin
                        sdio_out <= rd_shift_reg[7];
                        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                    end
                end
                if (sclk_fall && !active_reg) begin
                    sdio_oe_out <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fmt_reg <= `RST_OUT_FORMAT;
            drive_reg <= `RST_OUT_DRIVE;
            phase_reg <= `RST_OUT_PHASE;
            delay_reg <= `RST_OUT_DELAY;
            patt_lo_reg <= `RST_PATT;
            patt_hi_reg <= `RST_PATT;
        end else if (wr_strobe) begin
            case (addr_reg)
                `ADDR_OUT_FORMAT: fmt_reg <= wr_byte & `MASK_OUT_FORMAT;
                `ADDR_OUT_DRIVE: drive_reg <= wr_byte & `MASK_OUT_DRIVE;
                `ADDR_OUT_PHASE: phase_reg <= wr_byte & `MASK_OUT_PHASE;
                `ADDR_OUT_DELAY: delay_reg <= wr_byte & `MASK_OUT_DELAY;
                `ADDR_PATT1_LOW: patt_lo_reg <= wr_byte;
                `ADDR_PATT1_HIGH: patt_hi_reg <= wr_byte;
                default: patt_lo_reg <= patt_lo_reg;
            endcase
        end
    end

    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            io_supply_sel_out <= 2'h0;
            drive_strength_out <= `RST_OUT_DRIVE;
            user_pattern_one_out <= 16'h0000;
        end else begin
            io_supply_sel_out <= fmt_reg[`FMT_SUPPLY_HI:`FMT_SUPPLY_LO];
            drive_strength_out <= drive_reg;
            user_pattern_one_out <= {patt_hi_reg, patt_lo_reg};
        end
    end

    // ----------------------------------------
    // sample latch, divider phase and formatting
    // ----------------------------------------
    reg [2:0] div_cnt_reg;
    reg [7:0] hist_reg;
    reg [SAMPLE_W-1:0] word_reg;
    reg [SAMPLE_W-1:0] launch_reg;
    reg clk_lvl_reg;
    reg [SAMPLE_W-1:0] coded;
    wire latch = enc_tick_in & (div_cnt_reg == 3'h0);
    wire [7:0] hist_now = {hist_reg[6:0], latch};
    wire [2:0] phase_adj = phase_reg[`PHASE_ADJ_HI:`PHASE_ADJ_LO];
    wire phase_hit = hist_now[phase_adj];
    wire [15:0] patt_word = {patt_hi_reg, patt_lo_reg};
    wire [SAMPLE_W-1:0] src = user_pattern_sel_in ? patt_word[15:16-SAMPLE_W] : sample_in;

    always @* begin
        case (fmt_reg[`FMT_CODE_HI:`FMT_CODE_LO])
            `CODE_TWOS: coded = src ^ ({{(SAMPLE_W-1){1'b0}}, 1'b1} << (SAMPLE_W - 1));
            `CODE_GRAY: coded = src ^ (src >> 1);
            default: coded = src;
        endcase
        if (fmt_reg[`FMT_INVERT_BIT]) begin
            coded = ~coded;
        end
    end

    // the latch point follows the divider only; phase adjust moves the output side
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt_reg <= 3'h0;
            hist_reg <= 8'h00;
            word_reg <= {SAMPLE_W{1'b0}};
            launch_reg <= {SAMPLE_W{1'b0}};
            clk_lvl_reg <= 1'b0;
            data_oe_out <= 1'b0;
        end else begin
            data_oe_out <= ~fmt_reg[`FMT_DISABLE_BIT];
            if (enc_tick_in) begin
                div_cnt_reg <= (div_cnt_reg >= clk_div_ratio_in) ? 3'h0 : div_cnt_reg + 3'h1;
                hist_reg <= hist_now;
                if (latch) begin
                    word_reg <= coded;
                end
                if (phase_hit) begin
                    launch_reg <= word_reg;
                end
                clk_lvl_reg <= phase_hit ^ phase_reg[`PHASE_INVERT_BIT];
            end
        end
    end

    // ----------------------------------------
    // fine output delay
    // ----------------------------------------
    // steps below one clock period round up to whole cycles; a limitation of this clock rate
    wire [2:0] dly_code = delay_reg[`DLY_CODE_HI:`DLY_CODE_LO];
    wire [31:0] dly_ps = ({29'h0, dly_code} + 32'h1) * `DLY_STEP_PS;
    wire [31:0] dly_cyc = (dly_ps + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    wire [3:0] clk_tap = delay_reg[`DLY_CLK_EN_BIT] ? dly_cyc[3:0] : 4'h0;
    wire [3:0] data_tap = delay_reg[`DLY_DATA_EN_BIT] ? dly_cyc[3:0] : 4'h0;

    fine_delay_line #(.WIDTH(1), .DEPTH(DLY_DEPTH), .SEL_W(4)) clk_delay (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .data_in(clk_lvl_reg),
        .tap_in(clk_tap),
        .data_out(output_sample_clock_out)
    );

    fine_delay_line #(.WIDTH(SAMPLE_W), .DEPTH(DLY_DEPTH), .SEL_W(4)) data_delay (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .data_in(launch_reg),
        .tap_in(data_tap),
        .data_out(data_out)
    );

endmodule

/* File: sim/adc_fmt_sva.sv */
// checker for the output format block, bound from the bench top
// assumes the host keeps sclk phases >= 2 clocks and select low around writes
`timescale 1ns/100ps
module adc_fmt_sva #(
    parameter SAMPLE_W = 12
) (
    input wire clock_in,
    input wire nrst_in,
    input wire sclk_in,
    input wire csb_n_in,
    input wire enc_tick_in,
    input wire sdio_out,
    input wire sdio_oe_out,
    input wire [SAMPLE_W-1:0] data_out,
    input wire data_oe_out,
    input wire output_sample_clock_out,
    input wire [1:0] io_supply_sel_out,
    input wire [7:0] drive_strength_out,
    input wire [15:0] user_pattern_one_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // ----
    // cycles since the last tick or select activity
    // ----
    reg [3:0] quiet_reg;
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) quiet_reg <= 4'h0;
        else if (enc_tick_in || !csb_n_in) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
    end
    a_oe_select_idle: assert property (csb_n_in && $past(csb_n_in) |-> !sdio_oe_out)
        else $error("sdio driven while deselected");
    a_sdio_after_fall: assert property ($changed(sdio_out) |->
        (!$past(sclk_in) && $past(sclk_in, 2)) || $past(csb_n_in)) else $error("sdio moved off a fall");
    a_oe_rise_fall: assert property ($rose(sdio_oe_out) |-> !$past(sclk_in) && $past(sclk_in, 2))
        else $error("sdio enable rose off a fall");
    a_drive_in_xfer: assert property ($changed(drive_strength_out) |-> !$past(csb_n_in))
        else $error("drive strength moved outside a transfer");
    a_supply_in_xfer: assert property ($changed(io_supply_sel_out) |-> !$past(csb_n_in))
        else $error("supply select moved outside a transfer");
    a_pattern_in_xfer: assert property ($changed(user_pattern_one_out) |-> !$past(csb_n_in))
        else $error("pattern moved outside a transfer");
    a_disable_in_xfer: assert property ($changed(data_oe_out) |-> !$past(csb_n_in) || !$past(nrst_in, 2))
        else $error("data enable moved outside a transfer");
    a_out_edge_cause: assert property ($changed(data_out) || $changed(output_sample_clock_out) |->
        quiet_reg < 4'h8) else $error("output moved without a tick");
    c_write_seen: cover property ($changed(drive_strength_out));
    c_read_seen: cover property ($rose(sdio_oe_out));
    c_clock_rise: cover property ($rose(output_sample_clock_out));
endmodule

/* File: sim/spi_host_model.sv */
// host on the serial control port: drives sclk, select and sdio at falling edges
// assumes the sdio pin has a pull-down, so a released line reads low
`timescale 1ns/100ps
module spi_host_model (
    input wire clock_in,
    input wire sdio_in,
    input wire sdio_oe_in,
    output reg sclk_out,
    output reg csb_n_out,
    output wire sdio_out
);
    reg drv_en, drv_bit;
    assign sdio_out = sdio_oe_in ? sdio_in : (drv_en & drv_bit);
    initial begin
        sclk_out = 1'b0;
        csb_n_out = 1'b1;
        drv_en = 1'b0;
        drv_bit = 1'b0;
    end
    // sclk low and high two clocks each; read bit taken as sclk rises
    task automatic xfer(input reg rd, input reg [12:0] a, input integer n, input reg [23:0] wd,
        output reg [23:0] q);
        reg [39:0] sh;
        integer i;
        begin
            sh = {rd, 2'(n - 1), a, wd};
            q = 24'h000000;
            @(negedge clock_in) csb_n_out = 1'b0;
            for (i = 0; i < 16 + 8 * n; i = i + 1) begin
                @(negedge clock_in) sclk_out = 1'b0;
                drv_en = !rd || i < 16;
                drv_bit = sh[39 - i];
                repeat (2) @(negedge clock_in);
                sclk_out = 1'b1;
                if (rd && i >= 16) q = {q[22:0], sdio_oe_in ? sdio_in : 1'bx};
                @(negedge clock_in);
            end
            @(negedge clock_in) sclk_out = 1'b0;
            drv_en = 1'b0;
            repeat (2) @(negedge clock_in);
            csb_n_out = 1'b1;
            repeat (3) @(negedge clock_in);
        end
    endtask
endmodule

/* File: sim/adc_output_format_config_test.sv */
// self-checking bench: registers over the serial port, formatter and output clock
// assumes ticks every clock so one input clock cycle is one bench cycle
`timescale 1ns/100ps
`include "adc_fmt_map.vh"
module adc_output_format_config_test;
    reg clock_in, nrst_in, enc_tick_in, user_pattern_sel_in;
    reg [2:0] clk_div_ratio_in;
    reg [11:0] sample_in;
    wire sclk, csb_n, sdio_h, sdio_d, sdio_oe, data_oe, oclk;
    wire [11:0] data_out;
    wire [1:0] supply;
    wire [7:0] drive;
    wire [15:0] patt;
    integer bad_count, samples_checked, k, b, x;
    integer cyc = 0;
    reg [23:0] q;
    reg [28:0] row;
    reg [7:0] w, dw;
    reg [23:0] s_hist;
    reg [15:0] p;
    adc_output_format_config i_adc_output_format_config (.clock_in(clock_in), .nrst_in(nrst_in),
        .sclk_in(sclk), .csb_n_in(csb_n), .sdio_in(sdio_h), .sdio_out(sdio_d), .sdio_oe_out(sdio_oe),
        .enc_tick_in(enc_tick_in), .clk_div_ratio_in(clk_div_ratio_in), .user_pattern_sel_in(user_pattern_sel_in),
        .sample_in(sample_in), .data_out(data_out), .data_oe_out(data_oe), .output_sample_clock_out(oclk),
        .io_supply_sel_out(supply), .drive_strength_out(drive), .user_pattern_one_out(patt));
    spi_host_model i_spi_host_model (.clock_in(clock_in), .sdio_in(sdio_d), .sdio_oe_in(sdio_oe),
        .sclk_out(sclk), .csb_n_out(csb_n), .sdio_out(sdio_h));
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // s_hist[23:12] is the sample that the formatter latched three edges back
    always @(negedge clock_in) begin
        s_hist <= {s_hist[11:0], sample_in};
        sample_in <= $urandom;
    end
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count = bad_count + 1;
            test_done;
        end
    end
    task check(input [23:0] got, input [23:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [12:0] a, input [7:0] d);
        i_spi_host_model.xfer(1'b0, a, 1, {d, 16'h0000}, q);
    endtask
    task rd(input [12:0] a);
        i_spi_host_model.xfer(1'b1, a, 1, 24'h000000, q);
    endtask
    // first clock pulse position, modulo the divide-by-4 period
    task pos(output integer r);
        integer j;
        begin
            repeat (40) @(negedge clock_in);
            r = -1;
            for (j = 0; j < 20 && r < 0; j = j + 1) begin
                @(negedge clock_in);
                if (oclk === 1'b1) r = cyc % 4;
            end
        end
    endtask
    function [28:0] reg_row(input integer i);
        case (i)
            0: reg_row = {`ADDR_OUT_FORMAT, 8'h00, `MASK_OUT_FORMAT};
            1: reg_row = {`ADDR_OUT_DRIVE, 8'h22, 8'hFF};
            2: reg_row = {`ADDR_OUT_PHASE, 8'h00, `MASK_OUT_PHASE};
            3: reg_row = {`ADDR_OUT_DELAY, 8'h00, `MASK_OUT_DELAY};
            4: reg_row = {`ADDR_PATT1_LOW, 8'h00, 8'hFF};
            default: reg_row = {`ADDR_PATT1_HIGH, 8'h00, 8'hFF};
        endcase
    endfunction
    function [11:0] fmt(input [1:0] c, input inv, input [15:0] v);
        reg [11:0] s;
        begin
            s = v[15:4];
            if (c == 2'h1) s = s ^ 12'h800;
            else if (c == 2'h2) s = s ^ (s >> 1);
            fmt = inv ? ~s : s;
        end
    endfunction
    function integer dly(input integer n);
        dly = ((n + 1) * 560 + 3999) / 4000;
    endfunction
    task test_done;
        begin
            $display("checked %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        nrst_in = 1'b0;
        enc_tick_in = 1'b1;
        user_pattern_sel_in = 1'b0;
        clk_div_ratio_in = 3'h0;
        bad_count = 0;
        samples_checked = 0;
        k = $urandom(68484);
        repeat (16) @(negedge clock_in);
        nrst_in = 1'b1;
        repeat (3) @(negedge clock_in);
        check(drive, 8'h22);
        for (k = 0; k < 6; k = k + 1) begin
            row = reg_row(k);
            rd(row[28:16]);
            check(q[7:0], row[15:8]);
            w = $urandom;
            if (k == 1) dw = w;
            wr(row[28:16], w);
            rd(row[28:16]);
            check(q[7:0], w & row[7:0]);
        end
        check(drive, dw);
        wr(13'h0018, 8'h5A);
        rd(13'h0018);
        check(q[7:0], 8'h00);
        p = $urandom;
        i_spi_host_model.xfer(1'b0, `ADDR_PATT1_LOW, 2, {p[7:0], p[15:8], 8'h00}, q);
        check(patt, p);
        i_spi_host_model.xfer(1'b1, 13'h0018, 3, 24'h000000, q);
        check(q, {8'h00, p[7:0], p[15:8]});
        $display("registers done");
        user_pattern_sel_in = 1'b1;
        wr(`ADDR_OUT_PHASE, 8'h00);
        wr(`ADDR_OUT_DELAY, 8'h00);
        for (k = 0; k < 5; k = k + 1) begin
            wr(`ADDR_OUT_FORMAT, (k < 4 ? 8'h80 : 8'h04) | k[1:0]);
            repeat (20) @(negedge clock_in);
            check(data_out, fmt(k[1:0], k == 4, p));
            check(supply, k < 4 ? 2'h2 : 2'h0);
        end
        check(oclk, 1'b1);
        // live samples through the inverted offset binary path
        user_pattern_sel_in = 1'b0;
        repeat (4) @(negedge clock_in);
        for (k = 0; k < 16; k = k + 1) begin
            @(negedge clock_in);
            check(data_out, fmt(2'h0, 1'b1, {s_hist[23:12], 4'h0}));
        end
        wr(`ADDR_OUT_FORMAT, 8'h10);
        repeat (4) @(negedge clock_in);
        check(data_oe, 1'b0);
        wr(`ADDR_OUT_PHASE, 8'h80);
        repeat (20) @(negedge clock_in);
        check(oclk, 1'b0);
        $display("format done");
        clk_div_ratio_in = 3'h3;
        wr(`ADDR_OUT_PHASE, 8'h00);
        pos(b);
        for (k = 1; k < 8; k = k + 1) begin
            wr(`ADDR_OUT_PHASE, k[7:0]);
            pos(x);
            check(x, (b + k) % 4);
        end
        wr(`ADDR_OUT_PHASE, 8'h00);
        for (k = 0; k < 8; k = k + 7) begin
            wr(`ADDR_OUT_DELAY, 8'h80 | k[7:0]);
            pos(x);
            check(x, (b + dly(k)) % 4);
        end
        wr(`ADDR_OUT_DELAY, 8'h27);
        pos(x);
        check(x, b);
        $display("clock done");
        test_done;
    end
endmodule
bind adc_output_format_config adc_fmt_sva #(.SAMPLE_W(SAMPLE_W)) i_adc_fmt_sva (.clock_in(clock_in),
    .nrst_in(nrst_in), .sclk_in(sclk_in), .csb_n_in(csb_n_in), .enc_tick_in(enc_tick_in), .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe_out), .data_out(data_out), .data_oe_out(data_oe_out),
    .output_sample_clock_out(output_sample_clock_out), .io_supply_sel_out(io_supply_sel_out),
    .drive_strength_out(drive_strength_out), .user_pattern_one_out(user_pattern_one_out));
